// ==== design/opdv_regs.sv ====
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "opdv_map.svh"

// Summary of operation
// - power-on delay code sets driver wait
// - ramp step code sets time per step
// - one bit picks divider or bandgap common-mode
// - left top bit mutes, resets set
// - right top bit mutes, resets set
// - left code attenuates half dB per count
// - right code attenuates half dB per count
// - each output-stage input has volume and mute
// - up to seven volume controls, one per input
// - output-stage code steps about half dB
// - output-stage table, codes above 117 mute
// - link mode lets one channel follow other
module opdv_regs #(
	parameter int unsigned TICK_CYC   = `OPDV_TICK_CYC,
	parameter int unsigned RAMP_STEPS = `OPDV_RAMP_STEPS
) (
	// clock and reset
	input  wire logic                                clk,
	input  wire logic                                rstn,
	// ahb-lite slave
	input  wire logic                                hsel,
	input  wire logic [31:0]                         haddr,
	input  wire logic [1:0]                          htrans,
	input  wire logic                                hwrite,
	input  wire logic [2:0]                          hsize,
	input  wire logic [31:0]                         hwdata,
	input  wire logic                                hready,
	output logic                                     hreadyout,
	output logic                                     hresp,
	output logic [31:0]                              hrdata,
	// output driver power-up
	input  wire logic                                drv_power_req,
	output logic                                     drv_power_en,
	output logic [3:0]                               drv_ramp_level,
	output logic                                     drv_power_done,
	output logic                                     vcm_from_bandgap,
	// dac digital volume
	output logic                                     left_dac_mute,
	output logic [6:0]                               left_dac_atten,
	output logic                                     right_dac_mute,
	output logic [6:0]                               right_dac_atten,
	// output-stage analog volume controls
	input  wire logic [`OPDV_OS_CTRLS-1:0][6:0]      os_vol_code,
	output logic [`OPDV_OS_CTRLS-1:0][9:0]           os_atten_tenths,
	output logic [`OPDV_OS_CTRLS-1:0]                os_mute
);

	opdv_pkg::opdv_regs_st_t q, d;

	logic                            tmr_start;
	logic [22:0]                     tmr_ticks;
	logic                            tmr_done;
	logic [`OPDV_OS_CTRLS-1:0][9:0]  lut_atten;
	logic [`OPDV_OS_CTRLS-1:0]       lut_mute;

	// power-on delay in ticks of the time base
	function automatic logic [22:0] on_delay_ticks(input logic [3:0] code);
		case (code)
			4'h0: on_delay_ticks = 23'h0;
			4'h1: on_delay_ticks = 23'(`OPDV_DLY_1_US / `OPDV_TICK_US);
			4'h2: on_delay_ticks = 23'(`OPDV_DLY_2_US / `OPDV_TICK_US);
			4'h3: on_delay_ticks = 23'(`OPDV_DLY_3_US / `OPDV_TICK_US);
			4'h4: on_delay_ticks = 23'(`OPDV_DLY_4_US / `OPDV_TICK_US);
			4'h5: on_delay_ticks = 23'(`OPDV_DLY_5_US / `OPDV_TICK_US);
			4'h6: on_delay_ticks = 23'(`OPDV_DLY_6_US / `OPDV_TICK_US);
			4'h7: on_delay_ticks = 23'(`OPDV_DLY_7_US / `OPDV_TICK_US);
			4'h8: on_delay_ticks = 23'(`OPDV_DLY_8_US / `OPDV_TICK_US);
			4'h9: on_delay_ticks = 23'(`OPDV_DLY_9_US / `OPDV_TICK_US);
			4'ha: on_delay_ticks = 23'(`OPDV_DLY_10_US / `OPDV_TICK_US);
			4'hb: on_delay_ticks = 23'(`OPDV_DLY_11_US / `OPDV_TICK_US);
			// reserved codes saturate at the longest delay
			4'hc, 4'hd, 4'he, 4'hf: begin
				on_delay_ticks = 23'(`OPDV_DLY_11_US / `OPDV_TICK_US);
			end
			default: on_delay_ticks = 23'h0;
		endcase
	endfunction

	// ramp step time in ticks of the time base
	function automatic logic [22:0] ramp_step_ticks(input logic [1:0] code);
		case (code)
			2'h1: ramp_step_ticks = 23'(`OPDV_RAMP_1_MS * 1000 / `OPDV_TICK_US);
			2'h2: ramp_step_ticks = 23'(`OPDV_RAMP_2_MS * 1000 / `OPDV_TICK_US);
			2'h3: ramp_step_ticks = 23'(`OPDV_RAMP_3_MS * 1000 / `OPDV_TICK_US);
			default: ramp_step_ticks = 23'h0;
		endcase
	endfunction

	// register index of a bus address; misaligned or out-of-window addresses map to none
	function automatic logic [7:0] reg_index(input logic [31:0] addr);
		if (addr[31:10] != 22'h0 || addr[1:0] != 2'h0) begin
			reg_index = 8'h0;
		end else begin
			reg_index = addr[9:2];
		end
	endfunction

	// a transfer is taken when selected, the bus is ready and htrans is nonseq or seq
	function automatic logic bus_taken(
		input logic       sel,
		input logic       rdy,
		input logic [1:0] trans
	);
		bus_taken = sel && rdy && trans[1];
	endfunction

	// register file after a one-byte write; bit zero of pop is never stored
	function automatic opdv_pkg::opdv_regs_st_t reg_write(
		input opdv_pkg::opdv_regs_st_t s,
		input logic [7:0]              idx,
		input logic [7:0]              wb
	);
		opdv_pkg::opdv_regs_st_t r;
		r = s;
		case (idx)
			`OPDV_IDX_POP:   r.pop = wb & `OPDV_POP_WR_MASK;
			`OPDV_IDX_VOL_L: r.vol_l = wb;
			`OPDV_IDX_VOL_R: r.vol_r = wb;
			`OPDV_IDX_LINK:  r.link = wb[1:0];
			default: ;
		endcase
		return r;
	endfunction

	// effective volume byte of one channel
	function automatic logic [7:0] eff_vol(
		input logic [7:0] own,
		input logic [7:0] other,
		input logic       follow
	);
		eff_vol = follow ? other : own;
	endfunction

	// true when the step that just ended is the last of the ramp
	function automatic logic last_step(input logic [3:0] lvl);
		last_step = (32'(lvl) + 32'h1 >= RAMP_STEPS);
	endfunction

	// status byte: ramp steps done over the one-hot sequencer state
	function automatic logic [7:0] status_byte(input opdv_pkg::opdv_regs_st_t s);
		status_byte = {s.ramp_lvl, s.st};
	endfunction

	// read value of a register index, zero when unmapped
	function automatic logic [7:0] read_mux(
		input logic [7:0] idx,
		input opdv_pkg::opdv_regs_st_t s
	);
		case (idx)
			`OPDV_IDX_POP:    read_mux = s.pop & `OPDV_POP_WR_MASK;
			`OPDV_IDX_VOL_L:  read_mux = s.vol_l;
			`OPDV_IDX_VOL_R:  read_mux = s.vol_r;
			`OPDV_IDX_STATUS: read_mux = status_byte(s);
			`OPDV_IDX_LINK:   read_mux = {6'h0, s.link};
			default:          read_mux = 8'h0;
		endcase
	endfunction

	// one timer serves the power-on delay and every ramp step
	opdv_step_timer #(
		.TICK_CYC (TICK_CYC)
	) u_timer (
		.clk   (clk),
		.rstn  (rstn),
		.start (tmr_start),
		.ticks (tmr_ticks),
		.done  (tmr_done)
	);

	genvar gi;
	generate
		for (gi = 0; gi < `OPDV_OS_CTRLS; gi++) begin : g_os
			opdv_gain_lut u_lut (
				.code         (os_vol_code[gi]),
				.atten_tenths (lut_atten[gi]),
				.mute         (lut_mute[gi])
			);
		end
	endgenerate

	always_comb begin
		logic [7:0] wb;
		logic [7:0] l_eff;
		logic [7:0] r_eff;
		wb = hwdata[7:0];
		l_eff = 8'h0;
		r_eff = 8'h0;
		d = q;
		tmr_start = 1'b0;
		tmr_ticks = 23'h0;

		// data phase of a write
		if (q.dp_wr) begin
			d = reg_write(d, q.dp_idx, wb);
		end

		// address phase; reads see this cycle's write, so read-after-write returns new data
		d.dp_wr = 1'b0;
		if (bus_taken(hsel, hready, htrans)) begin
			d.dp_wr = hwrite;
			d.dp_idx = reg_index(haddr);
			d.rdata = hwrite ? 32'h0 : {24'h0, read_mux(d.dp_idx, d)};
		end

		// driver power-up sequence
		case (q.st)
			opdv_pkg::OPDV_IDLE: begin
				// ramp level clears two edges after the request drops
				d.ramp_lvl = 4'h0;
				if (drv_power_req) begin
					tmr_start = 1'b1;
					tmr_ticks = on_delay_ticks(q.pop[7:4]);
					d.st = opdv_pkg::OPDV_DELAY;
				end
			end
			opdv_pkg::OPDV_DELAY: begin
				if (!drv_power_req) begin
					d.st = opdv_pkg::OPDV_IDLE;
				end else if (tmr_done) begin
					tmr_start = 1'b1;
					tmr_ticks = ramp_step_ticks(q.pop[3:2]);
					d.st = opdv_pkg::OPDV_RAMP;
				end
			end
			opdv_pkg::OPDV_RAMP: begin
				if (!drv_power_req) begin
					d.st = opdv_pkg::OPDV_IDLE;
				end else if (tmr_done) begin
					d.ramp_lvl = q.ramp_lvl + 4'h1;
					if (last_step(q.ramp_lvl)) begin
						d.st = opdv_pkg::OPDV_ON;
					end else begin
						tmr_start = 1'b1;
						tmr_ticks = ramp_step_ticks(q.pop[3:2]);
					end
				end
			end
			// drivers stay powered until the request drops
			opdv_pkg::OPDV_ON: begin
				if (!drv_power_req) begin
					d.st = opdv_pkg::OPDV_IDLE;
				end
			end
			default: d.st = opdv_pkg::OPDV_IDLE;
		endcase

		// effective dac volume; following copies the whole register, mute bit included
		l_eff = eff_vol(d.vol_l, d.vol_r, d.link == `OPDV_LINK_L_FOLLOWS);
		r_eff = eff_vol(d.vol_r, d.vol_l, d.link == `OPDV_LINK_R_FOLLOWS);
		d.l_mute = l_eff[`OPDV_VOL_MUTE_BIT];
		d.l_atten = l_eff[6:0];
		d.r_mute = r_eff[`OPDV_VOL_MUTE_BIT];
		d.r_atten = r_eff[6:0];

		d.os_atten = lut_atten;
		d.os_mute = lut_mute;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q.pop <= `OPDV_POP_RST;
			q.vol_l <= `OPDV_VOL_RST;
			q.vol_r <= `OPDV_VOL_RST;
			q.link <= `OPDV_LINK_RST;
			q.dp_wr <= 1'b0;
			q.dp_idx <= 8'h0;
			q.rdata <= 32'h0;
			q.st <= opdv_pkg::OPDV_IDLE;
			q.ramp_lvl <= 4'h0;
			q.l_mute <= 1'b1;
			q.l_atten <= 7'h0;
			q.r_mute <= 1'b1;
			q.r_atten <= 7'h0;
			q.os_atten <= '0;
			q.os_mute <= '0;
		end else begin
			q <= d;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = q.rdata;
	assign drv_power_en = q.st[2] | q.st[3];
	assign drv_ramp_level = q.ramp_lvl;
	assign drv_power_done = q.st[3];
	assign vcm_from_bandgap = q.pop[`OPDV_POP_VCM_BIT];
	assign left_dac_mute = q.l_mute;
	assign left_dac_atten = q.l_atten;
	assign right_dac_mute = q.r_mute;
	assign right_dac_atten = q.r_atten;
	assign os_atten_tenths = q.os_atten;
	assign os_mute = q.os_mute;

endmodule

// ==== pkg/opdv_map.svh ====
`ifndef OPDV_MAP_SVH
`define OPDV_MAP_SVH

// clock and time base
`define OPDV_CLK_MHZ        40
`define OPDV_TICK_US        10
`define OPDV_TICK_CYC       (`OPDV_CLK_MHZ * `OPDV_TICK_US)

// register indices; byte address is four times the index
`define OPDV_IDX_POP        8'h2a
`define OPDV_IDX_VOL_L      8'h2b
`define OPDV_IDX_VOL_R      8'h2c
`define OPDV_IDX_STATUS     8'h2d
`define OPDV_IDX_LINK       8'h2e

// reset values
`define OPDV_POP_RST        8'h00
`define OPDV_VOL_RST        8'h80
`define OPDV_LINK_RST       2'h0

// field positions
`define OPDV_POP_DLY_LSB    4
`define OPDV_POP_RAMP_LSB   2
`define OPDV_POP_VCM_BIT    1
`define OPDV_VOL_MUTE_BIT   7
`define OPDV_POP_WR_MASK    8'hfe

// volume follow modes
`define OPDV_LINK_L_FOLLOWS 2'h1
`define OPDV_LINK_R_FOLLOWS 2'h2

// power-on delays in microseconds
`define OPDV_DLY_1_US       10
`define OPDV_DLY_2_US       100
`define OPDV_DLY_3_US       1000
`define OPDV_DLY_4_US       10000
`define OPDV_DLY_5_US       50000
`define OPDV_DLY_6_US       100000
`define OPDV_DLY_7_US       200000
`define OPDV_DLY_8_US       400000
`define OPDV_DLY_9_US       800000
`define OPDV_DLY_10_US      2000000
`define OPDV_DLY_11_US      4000000

// ramp-up step times in milliseconds
`define OPDV_RAMP_1_MS      1
`define OPDV_RAMP_2_MS      2
`define OPDV_RAMP_3_MS      4
`define OPDV_RAMP_STEPS     8

// output-stage gain table
`define OPDV_OS_CTRLS       7
`define OPDV_OS_LIN_MAX     36
`define OPDV_OS_LAST        117
`define OPDV_OS_STEP_TENTHS 5
`define OPDV_OS_MUTE_ATTEN  10'h3ff

`endif

// ==== pkg/opdv_pkg.sv ====
`include "opdv_map.svh"

package opdv_pkg;

	typedef enum logic [3:0] {
		OPDV_IDLE  = 4'b0001,
		OPDV_DELAY = 4'b0010,
		OPDV_RAMP  = 4'b0100,
		OPDV_ON    = 4'b1000
	} opdv_state_t;

	typedef struct packed {
		logic [31:0] cnt;
		logic        run;
		logic        done;
	} opdv_timer_st_t;

	typedef struct packed {
		logic [7:0]                              pop;
		logic [7:0]                              vol_l;
		logic [7:0]                              vol_r;
		logic [1:0]                              link;
		logic                                    dp_wr;
		logic [7:0]                              dp_idx;
		logic [31:0]                             rdata;
		opdv_state_t                             st;
		logic [3:0]                              ramp_lvl;
		logic                                    l_mute;
		logic [6:0]                              l_atten;
		logic                                    r_mute;
		logic [6:0]                              r_atten;
		logic [`OPDV_OS_CTRLS-1:0][9:0]          os_atten;
		logic [`OPDV_OS_CTRLS-1:0]               os_mute;
	} opdv_regs_st_t;

endpackage

// ==== design/opdv_step_timer.sv ====
`timescale 1ns/1ps
`include "opdv_map.svh"

// counts a number of time ticks; done pulses once when the time has run out
module opdv_step_timer #(
	parameter int unsigned TICK_CYC = `OPDV_TICK_CYC
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// control
	input  wire logic        start,
	input  wire logic [22:0] ticks,
	output logic             done
);

	opdv_pkg::opdv_timer_st_t q, d;

	always_comb begin
		d = q;
		d.done = 1'b0;
		if (start) begin
			if (ticks == 23'h0) begin
				d.done = 1'b1;
				d.run = 1'b0;
			end else begin
				d.cnt = 32'(ticks * TICK_CYC) - 32'h1;
				d.run = 1'b1;
			end
		end else if (q.run) begin
			if (q.cnt == 32'h0) begin
				d.done = 1'b1;
				d.run = 1'b0;
			end else begin
				d.cnt = q.cnt - 32'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign done = q.done;

endmodule

// ==== design/opdv_gain_lut.sv ====
`timescale 1ns/1ps
`include "opdv_map.svh"

// output-stage analog volume code to attenuation in tenths of a dB
module opdv_gain_lut (
	// code in
	input  wire logic [6:0] code,
	// gain out
	output logic [9:0]      atten_tenths,
	output logic            mute
);

	localparam logic [9:0] TBL [37:117] = '{
		10'd186, 10'd191, 10'd196, 10'd201, 10'd206, 10'd211, 10'd216, 10'd221, 10'd226,
		10'd231, 10'd236, 10'd241, 10'd246, 10'd251, 10'd256, 10'd261, 10'd266, 10'd271,
		10'd276, 10'd281, 10'd286, 10'd291, 10'd296, 10'd301, 10'd306, 10'd311, 10'd316,
		10'd321, 10'd326, 10'd331, 10'd336, 10'd341, 10'd346, 10'd351, 10'd357, 10'd361,
		10'd367, 10'd371, 10'd377, 10'd382, 10'd387, 10'd392, 10'd397, 10'd402, 10'd407,
		10'd412, 10'd417, 10'd422, 10'd427, 10'd432, 10'd438, 10'd443, 10'd448, 10'd452,
		10'd458, 10'd462, 10'd467, 10'd474, 10'd479, 10'd482, 10'd487, 10'd493, 10'd500,
		10'd503, 10'd510, 10'd514, 10'd518, 10'd522, 10'd527, 10'd537, 10'd542, 10'd553,
		10'd567, 10'd583, 10'd602, 10'd627, 10'd643, 10'd662, 10'd687, 10'd722, 10'd783
	};

	always_comb begin
		mute = 1'b0;
		if (code <= 7'(`OPDV_OS_LIN_MAX)) begin
			atten_tenths = 10'(code * `OPDV_OS_STEP_TENTHS);
		end else if (code <= 7'(`OPDV_OS_LAST)) begin
			atten_tenths = TBL[code];
		end else begin
			atten_tenths = `OPDV_OS_MUTE_ATTEN;
			mute = 1'b1;
		end
	end

endmodule

// ==== bench/opdv_regs_properties.sv ====
`timescale 1ns/1ps
`include "opdv_map.svh"

module opdv_regs_properties #(
	parameter int unsigned TICK_CYC   = 1,
	parameter int unsigned RAMP_STEPS = 8
) (
	// clock and reset
	input wire logic                           clk,
	input wire logic                           rstn,
	// bus
	input wire logic                           hsel,
	input wire logic [31:0]                    haddr,
	input wire logic [1:0]                     htrans,
	input wire logic                           hwrite,
	input wire logic [31:0]                    hwdata,
	input wire logic                           hready,
	// driver and volume
	input wire logic                           drv_power_req,
	input wire logic                           drv_power_en,
	input wire logic [3:0]                     drv_ramp_level,
	input wire logic                           drv_power_done,
	input wire logic                           vcm_from_bandgap,
	input wire logic                           left_dac_mute,
	input wire logic [6:0]                     left_dac_atten,
	input wire logic                           right_dac_mute,
	input wire logic [6:0]                     right_dac_atten,
	input wire logic [`OPDV_OS_CTRLS-1:0][6:0] os_vol_code,
	input wire logic [`OPDV_OS_CTRLS-1:0][9:0] os_atten_tenths,
	input wire logic [`OPDV_OS_CTRLS-1:0]      os_mute
);
	// write data phase tracking, link mode and pop copy
	logic       wp;
	logic [7:0] wi;
	logic [1:0] lk;
	logic [7:0] pp;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wp <= 1'b0;
			wi <= 8'h00;
			lk <= 2'h0;
			pp <= 8'h00;
		end else begin
			wp <= hsel && hready && htrans[1] && hwrite;
			wi <= haddr[9:2];
			if (wp && wi == `OPDV_IDX_LINK)
				lk <= hwdata[1:0];
			if (wp && wi == `OPDV_IDX_POP)
				pp <= hwdata[7:0];
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_left;
		(wp && wi == `OPDV_IDX_VOL_L && lk != 2'h1) |=>
			{left_dac_mute, left_dac_atten} == $past(hwdata[7:0]);
	endproperty
	a_left: assert property (p_left) else $error("left volume wrong");
	property p_right;
		(wp && wi == `OPDV_IDX_VOL_R && lk != 2'h2) |=>
			{right_dac_mute, right_dac_atten} == $past(hwdata[7:0]);
	endproperty
	a_right: assert property (p_right) else $error("right volume wrong");
	property p_follow;
		(wp && wi == `OPDV_IDX_VOL_R && lk == 2'h1) |=>
			{left_dac_mute, left_dac_atten} == $past(hwdata[7:0]);
	endproperty
	a_follow: assert property (p_follow) else $error("left not following");
	property p_vcm;
		(wp && wi == `OPDV_IDX_POP) |=> vcm_from_bandgap == $past(hwdata[1]);
	endproperty
	a_vcm: assert property (p_vcm) else $error("vcm source wrong");
	property p_os_mute;
		1'b1 |=> os_mute[4] == ($past(os_vol_code[4]) > 7'd117);
	endproperty
	a_os_mute: assert property (p_os_mute) else $error("stage mute wrong");
	property p_os_lin;
		(os_vol_code[1] <= 7'd36) |=> os_atten_tenths[1] == 10'd5 * $past(os_vol_code[1]);
	endproperty
	a_os_lin: assert property (p_os_lin) else $error("stage step wrong");
	property p_rlvl;
		drv_power_done |-> drv_power_en && drv_ramp_level == 4'(RAMP_STEPS);
	endproperty
	a_rlvl: assert property (p_rlvl) else $error("ramp count wrong");
	property p_dly0;
		($rose(drv_power_req) && pp[7:4] == 4'h0) |-> ##[1:4] drv_power_en;
	endproperty
	a_dly0: assert property (p_dly0) else $error("zero delay too long");
endmodule

bind opdv_regs opdv_regs_properties #(.TICK_CYC(TICK_CYC), .RAMP_STEPS(RAMP_STEPS)) u_props (
	.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .drv_power_req,
	.drv_power_en, .drv_ramp_level, .drv_power_done, .vcm_from_bandgap, .left_dac_mute,
	.left_dac_atten, .right_dac_mute, .right_dac_atten, .os_vol_code, .os_atten_tenths,
	.os_mute);

// ==== bench/output_pop_and_dac_volume_regs_tb.sv ====
`timescale 1ns/1ps
`include "opdv_map.svh"

module output_pop_and_dac_volume_regs_tb;
	logic                  clk = 1'b0;
	logic                  rstn, hsel, hwrite, hready, hreadyout, hresp, drv_power_req;
	logic                  drv_power_en, drv_power_done, vcm_from_bandgap;
	logic                  left_dac_mute, right_dac_mute;
	logic                  rph = 1'b0;
	logic [1:0]            htrans;
	logic [2:0]            hsize = 3'h2;
	logic [3:0]            drv_ramp_level;
	logic [6:0]            left_dac_atten, right_dac_atten, os_mute;
	logic [31:0]           haddr, hwdata, hrdata;
	logic [6:0][6:0]       os_vol_code;
	logic [6:0][9:0]       os_atten_tenths;
	logic [31:0]           exp_q[$];
	int                    mismatches = 0;
	int                    checks = 0;

	assign hready = hreadyout;
	always #12.5 clk = ~clk;

	opdv_regs #(.TICK_CYC(1), .RAMP_STEPS(8)) opdv_regs_inst (.clk, .rstn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
		.drv_power_req, .drv_power_en, .drv_ramp_level, .drv_power_done, .vcm_from_bandgap,
		.left_dac_mute, .left_dac_atten, .right_dac_mute, .right_dac_atten, .os_vol_code,
		.os_atten_tenths, .os_mute);

	task print_verdict;
		if (mismatches == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	// bounded wait for a level; running out ends the run
	task wt(input int sel);
		int n;
		n = 0;
		@(posedge clk);
		while ((sel == 0 ? hreadyout : sel == 1 ? drv_power_en : drv_power_done) !== 1'b1) begin
			n++;
			if (n > 20000) begin
				mismatches++;
				print_verdict;
			end
			@(posedge clk);
		end
	endtask

	task xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {22'h0, i, 2'b00};
		wt(0);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wt(0);
	endtask

	task wr(input logic [7:0] i, input logic [7:0] d);
		xfer(1'b1, i, {24'h0, d});
	endtask

	task rd(input logic [7:0] i, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		xfer(1'b0, i, 32'h0);
	endtask

	// read data checker: oldest note against the data phase
	always @(posedge clk) begin
		if (rph) begin
			chk("hrdata", exp_q.size() > 0 ? exp_q.pop_front() : 32'hx, hrdata);
			chk("hresp", 32'h0, {31'h0, hresp});
		end
		rph <= rstn && hsel && hready && htrans[1] && !hwrite;
	end

	function automatic logic [9:0] osx(input int c);
		return c <= 36 ? 10'(5 * c) : c == 37 ? 10'd186 : c == 117 ? 10'd783 : 10'h3ff;
	endfunction

	initial begin
		logic [7:0] v, w;
		int         t, cyc;
		int         dt[6];
		int         oc[7];
		dt = '{0, 1, 10, 100, 1000, 5000};
		oc = '{0, 36, 37, 117, 118, 127, 0};
		rstn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0;
		hwdata = 32'h0;
		drv_power_req = 1'b0;
		os_vol_code = '0;
		void'($urandom(32'hfe48));
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		rd(`OPDV_IDX_POP, `OPDV_POP_RST);
		rd(`OPDV_IDX_VOL_L, 8'h80);
		rd(`OPDV_IDX_VOL_R, 8'h80);
		rd(8'h30, 8'h00);
		@(negedge clk);
		chk("mutes", 32'h3, {30'h0, left_dac_mute, right_dac_mute});
		for (int k = 0; k < 4; k++) begin
			v = k == 0 ? 8'h7f : k == 1 ? 8'h00 : 8'($urandom);
			w = k == 1 ? 8'hff : 8'($urandom);
			wr(`OPDV_IDX_VOL_L, v);
			wr(`OPDV_IDX_VOL_R, w);
			@(negedge clk);
			chk("left_dac", {24'h0, v}, {24'h0, left_dac_mute, left_dac_atten});
			chk("right_dac", {24'h0, w}, {24'h0, right_dac_mute, right_dac_atten});
			rd(`OPDV_IDX_VOL_L, v);
			rd(`OPDV_IDX_VOL_R, w);
		end
		for (int m = 0; m < 4; m++) begin
			wr(`OPDV_IDX_LINK, 8'(m));
			rd(`OPDV_IDX_LINK, 8'(m));
			wr(`OPDV_IDX_VOL_R, w);
			@(negedge clk);
			chk("left_eff", {24'h0, m == 1 ? w : v}, {24'h0, left_dac_mute, left_dac_atten});
			chk("right_eff", {24'h0, m == 2 ? v : w}, {24'h0, right_dac_mute, right_dac_atten});
		end
		for (int k = 0; k < 4; k++) begin
			v = 8'($urandom) & `OPDV_POP_WR_MASK & 8'hbf;
			wr(`OPDV_IDX_POP, v);
			@(negedge clk);
			chk("vcm", {31'h0, v[1]}, {31'h0, vcm_from_bandgap});
			rd(`OPDV_IDX_POP, v);
		end
		// delay codes 0..5 with zero ramp, then ramp codes 0..3 with zero delay
		for (int k = 0; k < 10; k++) begin
			v = k < 6 ? {4'(k), 4'h0} : {4'h0, 2'(k - 6), 2'b00};
			t = k < 6 ? 0 : k == 6 ? 0 : 100 << (k - 7);
			wr(`OPDV_IDX_POP, v);
			@(posedge clk);
			drv_power_req <= 1'b1;
			cyc = $time / 25;
			wt(1);
			cyc = $time / 25 - cyc;
			chk("delay", 32'h1, {31'h0, cyc >= (k < 6 ? dt[k] : 0) && cyc <= (k < 6 ? dt[k] : 0) + 4});
			cyc = $time / 25;
			wt(2);
			cyc = $time / 25 - cyc;
			chk("ramp", 32'h1, {31'h0, cyc >= 8 * t && cyc <= 8 * (t + 3) + 4});
			rd(`OPDV_IDX_STATUS, 8'h88);
			drv_power_req <= 1'b0;
			repeat (3) @(negedge clk);
			chk("off", 32'h0, {26'h0, drv_power_en, drv_power_done, drv_ramp_level});
		end
		oc[6] = $urandom % 37;
		@(posedge clk);
		for (int i = 0; i < 7; i++)
			os_vol_code[i] <= 7'(oc[i]);
		@(posedge clk);
		@(negedge clk);
		for (int i = 0; i < 7; i++) begin
			chk("os_atten", {22'h0, osx(oc[i])}, {22'h0, os_atten_tenths[i]});
			chk("os_mute", {31'h0, oc[i] > 117}, {31'h0, os_mute[i]});
		end
		print_verdict;
	end
endmodule
